// [design/shift_compare_halfword_exec.sv]
// sign-extend, halfword store, left shift and compare unit
// assumes apb master, translator and memory on sys_clk
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps

module shift_compare_halfword_exec (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output shift_compare_halfword_pkg::xlate_req_s xlate_req,
   input wire shift_compare_halfword_pkg::xlate_rsp_s xlate_rsp,
   output shift_compare_halfword_pkg::mem_req_s mem_req,
   input wire logic mem_ready,
   output logic issue_break
);

   // -------------------------------------------------------------------
   // state and storage
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      idle_st = 2'b00,
      exec_st = 2'b01,
      xlate_st = 2'b10,
      mem_st = 2'b11
   } state_e;

   state_e state_ff;
   logic [31:0] general_register_file [32];
   logic [7:0] ctrl_ff;
   logic [31:0] instr_ff;
   logic [4:0] gpr_sel_ff;
   logic [31:0] prdata_ff;
   shift_compare_halfword_pkg::exc_e exc_ff;
   logic done_ff;
   logic [7:0] break_cnt_ff;
   logic break_ff;
   logic is_user_store_ff;
   logic [31:0] store_data_ff;
   shift_compare_halfword_pkg::xlate_req_s xlate_req_ff;
   shift_compare_halfword_pkg::mem_req_s mem_req_ff;

   // -------------------------------------------------------------------
   // apb decode
   // -------------------------------------------------------------------
   logic apb_setup;
   logic apb_access;
   logic apb_wr;
   logic addr_hit;
   logic busy;
   logic instr_refused;

   assign busy = (state_ff != idle_st);
   assign apb_setup = psel & ~penable;
   assign apb_access = psel & penable;
   assign apb_wr = apb_access & pwrite;
   // offsets are word aligned and contiguous from zero
   assign addr_hit = (paddr[1:0] == 2'b00) && (paddr <= shift_compare_halfword_pkg::gpr_data_off);

   // an instruction while busy is refused, not queued
   assign instr_refused = busy && (paddr == shift_compare_halfword_pkg::instr_off) && pwrite;
   assign pready = 1'b1;
   assign pslverr = apb_access & (~addr_hit | instr_refused);
   assign prdata = prdata_ff;

   logic wr_ctrl;
   logic wr_instr;
   logic wr_status;
   logic wr_sel;
   logic wr_gpr;
   assign wr_ctrl = apb_wr && (paddr == shift_compare_halfword_pkg::ctrl_off);
   assign wr_instr = apb_wr && (paddr == shift_compare_halfword_pkg::instr_off) && !busy;
   assign wr_status = apb_wr && (paddr == shift_compare_halfword_pkg::status_off);
   assign wr_sel = apb_wr && (paddr == shift_compare_halfword_pkg::gpr_sel_off);
   assign wr_gpr = apb_wr && (paddr == shift_compare_halfword_pkg::gpr_data_off);

   // -------------------------------------------------------------------
   // instruction fields and operands
   // -------------------------------------------------------------------
   logic [3:0] op_code;
   logic [4:0] reg_a;
   logic [4:0] reg_b;
   logic [4:0] dest_reg;
   logic [4:0] shift_amount_field;
   logic [15:0] imm16;
   logic [31:0] source_reg_a;
   logic [31:0] source_reg_b;
   logic [31:0] imm_sx;
   logic [31:0] user_off_sx;
   logic [3:0] release_lvl;
   logic extended_vaddr_present_bit;
   logic big_endian_core_flag;
   logic swapped_endian_user_flag;
   logic superscalar;

   assign op_code = instr_ff[shift_compare_halfword_pkg::op_lsb +: 4];
   assign reg_a = instr_ff[shift_compare_halfword_pkg::reg_a_lsb +: 5];
   assign reg_b = instr_ff[shift_compare_halfword_pkg::reg_b_lsb +: 5];
   assign dest_reg = instr_ff[shift_compare_halfword_pkg::dest_lsb +: 5];
   assign shift_amount_field = instr_ff[shift_compare_halfword_pkg::dest_lsb +: 5];
   assign imm16 = instr_ff[15:0];
   assign imm_sx = {{16{imm16[15]}}, imm16};
   assign user_off_sx = {{23{imm16[shift_compare_halfword_pkg::user_off_msb]}},
                         imm16[shift_compare_halfword_pkg::user_off_msb:0]};
   // register zero always reads back as zero
   assign source_reg_a = (reg_a == 5'h00) ? 32'h0000_0000 : general_register_file[reg_a];
   assign source_reg_b = (reg_b == 5'h00) ? 32'h0000_0000 : general_register_file[reg_b];
   assign release_lvl = ctrl_ff[shift_compare_halfword_pkg::ctrl_release_lsb +: 4];
   assign extended_vaddr_present_bit = ctrl_ff[shift_compare_halfword_pkg::ctrl_eva_bit];
   assign big_endian_core_flag = ctrl_ff[shift_compare_halfword_pkg::ctrl_big_endian_bit];
   assign swapped_endian_user_flag = ctrl_ff[shift_compare_halfword_pkg::ctrl_swapped_endian_bit];
   assign superscalar = ctrl_ff[shift_compare_halfword_pkg::ctrl_superscalar_bit];

   // -------------------------------------------------------------------
   // combinational execute
   // -------------------------------------------------------------------
   logic nxt_wr_en;
   logic [4:0] nxt_wr_idx;
   logic [31:0] nxt_result;
   logic nxt_is_store;
   logic nxt_is_user_store;
   logic [31:0] nxt_vaddr;
   logic nxt_break;
   shift_compare_halfword_pkg::exc_e nxt_exc;

   always_comb begin
      nxt_wr_en = 1'b0;
      nxt_wr_idx = dest_reg;
      nxt_result = 32'h0000_0000;
      nxt_is_store = 1'b0;
      nxt_is_user_store = 1'b0;
      nxt_vaddr = source_reg_a + imm_sx;
      nxt_break = 1'b0;
      nxt_exc = shift_compare_halfword_pkg::exc_none;
      case (op_code)
         shift_compare_halfword_pkg::seh_op: begin
            nxt_wr_idx = reg_b;
            nxt_result = {{16{source_reg_a[15]}}, source_reg_a[15:0]};
            if (release_lvl < shift_compare_halfword_pkg::min_release) begin
               nxt_exc = shift_compare_halfword_pkg::exc_reserved_instr;
            end else begin
               nxt_wr_en = 1'b1;
            end
         end
         shift_compare_halfword_pkg::store_halfword_op: begin
            nxt_is_store = 1'b1;
         end
         shift_compare_halfword_pkg::store_halfword_user_space_op: begin
            nxt_vaddr = source_reg_a + user_off_sx;
            if (!extended_vaddr_present_bit) begin
               nxt_exc = shift_compare_halfword_pkg::exc_reserved_instr;
            end else begin
               nxt_is_store = 1'b1;
               nxt_is_user_store = 1'b1;
            end
         end
         shift_compare_halfword_pkg::shift_left_immediate_op: begin
            nxt_wr_idx = reg_b;
            nxt_result = source_reg_a << shift_amount_field;
            // both r0 forms write nothing; only the sa of one breaks issue
            if (reg_a == 5'h00 && reg_b == 5'h00) begin
               nxt_break = superscalar && (shift_amount_field == 5'h01);
            end else begin
               nxt_wr_en = 1'b1;
            end
         end
         shift_compare_halfword_pkg::shift_left_variable_op: begin
            nxt_result = source_reg_b << source_reg_a[4:0];
            nxt_wr_en = 1'b1;
         end
         shift_compare_halfword_pkg::set_if_less_signed_op: begin
            nxt_result = {31'h0, ($signed(source_reg_a) < $signed(source_reg_b))};
            nxt_wr_en = 1'b1;
         end
         shift_compare_halfword_pkg::set_if_less_signed_imm_op: begin
            nxt_wr_idx = reg_b;
            nxt_result = {31'h0, ($signed(source_reg_a) < $signed(imm_sx))};
            nxt_wr_en = 1'b1;
         end
         shift_compare_halfword_pkg::set_if_less_unsigned_imm_op: begin
            nxt_wr_idx = reg_b;
            nxt_result = {31'h0, (source_reg_a < imm_sx)};
            nxt_wr_en = 1'b1;
         end
         shift_compare_halfword_pkg::set_if_less_unsigned_op: begin
            nxt_result = {31'h0, (source_reg_a < source_reg_b)};
            nxt_wr_en = 1'b1;
         end
         default: begin
            nxt_exc = shift_compare_halfword_pkg::exc_reserved_instr;
         end
      endcase
      // compares have no overflow path
      nxt_wr_en = nxt_wr_en && (nxt_exc == shift_compare_halfword_pkg::exc_none);
      if (nxt_is_store && nxt_vaddr[0]) begin
         nxt_exc = shift_compare_halfword_pkg::exc_address_error;
         nxt_is_store = 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // translation answer
   // -------------------------------------------------------------------
   logic rsp_tlb_exc;
   logic seg_reachable;
   logic [1:0] lane;
   logic [31:0] phys_addr;

   // other translator codes are not reported
   assign rsp_tlb_exc = xlate_rsp.exc inside {[shift_compare_halfword_pkg::exc_tlb_refill:
                                                shift_compare_halfword_pkg::exc_watch]};

   // plain stores reach every mode; user stores reach every mode but kernel-only
   assign seg_reachable = !is_user_store_ff ||
                          (xlate_rsp.seg_mode != shift_compare_halfword_pkg::kernel_only_seg_mode);
   assign lane = xlate_req_ff.vaddr[1:0] ^ {big_endian_core_flag, 1'b0};
   assign phys_addr = {xlate_rsp.paddr[31:2],
                       xlate_rsp.paddr[1:0] ^ {swapped_endian_user_flag, 1'b0}};

   // -------------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------------
   logic store_exc;
   logic store_done;
   logic exec_done;
   assign store_exc = (state_ff == xlate_st) && xlate_rsp.valid && (rsp_tlb_exc || !seg_reachable);
   assign store_done = (state_ff == mem_st) && mem_ready;
   assign exec_done = ((state_ff == exec_st) && !nxt_is_store) || store_exc || store_done;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= idle_st;
      end else begin
         unique case (state_ff)
            idle_st: begin
               if (wr_instr) begin
                  state_ff <= exec_st;
               end
            end
            exec_st: begin
               state_ff <= nxt_is_store ? xlate_st : idle_st;
            end
            xlate_st: begin
               if (xlate_rsp.valid) begin
                  state_ff <= store_exc ? idle_st : mem_st;
               end
            end
            mem_st: begin
               if (mem_ready) begin
                  state_ff <= idle_st;
               end
            end
         endcase
      end
   end

   // translation request, held until answered
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         xlate_req_ff <= '0;
         is_user_store_ff <= 1'b0;
         store_data_ff <= 32'h0000_0000;
      end else if (state_ff == exec_st && nxt_is_store) begin
         xlate_req_ff.valid <= 1'b1;
         xlate_req_ff.vaddr <= nxt_vaddr;
         xlate_req_ff.user_map <= nxt_is_user_store;
         is_user_store_ff <= nxt_is_user_store;
         store_data_ff <= source_reg_b;
      end else if (state_ff == xlate_st && xlate_rsp.valid) begin
         xlate_req_ff.valid <= 1'b0;
      end
   end

   // memory write, held until accepted
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_req_ff <= '0;
      end else if (state_ff == xlate_st && xlate_rsp.valid && !store_exc) begin
         mem_req_ff.valid <= 1'b1;
         mem_req_ff.paddr <= phys_addr;
         mem_req_ff.vaddr <= xlate_req_ff.vaddr;
         mem_req_ff.lane <= lane;
         mem_req_ff.data <= store_data_ff << {lane, 3'b000};
      end else if (store_done) begin
         mem_req_ff.valid <= 1'b0;
      end
   end

   assign xlate_req = xlate_req_ff;
   assign mem_req = mem_req_ff;
   assign issue_break = break_ff;

   // -------------------------------------------------------------------
   // register file; exec writes win over software writes
   // -------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (state_ff == exec_st && nxt_wr_en && nxt_wr_idx != 5'h00) begin
         general_register_file[nxt_wr_idx] <= nxt_result;
      end else if (wr_gpr && gpr_sel_ff != 5'h00) begin
         general_register_file[gpr_sel_ff] <= pwdata;
      end
   end

   // -------------------------------------------------------------------
   // software registers
   // -------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= shift_compare_halfword_pkg::ctrl_reset;
         gpr_sel_ff <= 5'h00;
         instr_ff <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= pwdata[7:0];
         end
         if (wr_sel) begin
            gpr_sel_ff <= pwdata[4:0];
         end
         if (wr_instr) begin
            instr_ff <= pwdata;
         end
      end
   end

   // status: last exception, done flag, break count
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         exc_ff <= shift_compare_halfword_pkg::exc_none;
         done_ff <= 1'b0;
         break_cnt_ff <= 8'h00;
         break_ff <= 1'b0;
      end else begin
         break_ff <= (state_ff == exec_st) && nxt_break;
         if (state_ff == exec_st) begin
            exc_ff <= nxt_exc;
            break_cnt_ff <= break_cnt_ff + {7'h00, nxt_break};
         end else if (store_exc) begin
            exc_ff <= seg_reachable ? xlate_rsp.exc : shift_compare_halfword_pkg::exc_address_error;
         end
         // completion beats a same-cycle clear
         if (exec_done) begin
            done_ff <= 1'b1;
         end else if (wr_status && pwdata[shift_compare_halfword_pkg::status_done_bit]) begin
            done_ff <= 1'b0;
         end
      end
   end

   // read data latched in setup, shown in access
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= 32'h0000_0000;
      end else if (apb_setup && !pwrite) begin
         unique case (paddr)
            shift_compare_halfword_pkg::ctrl_off: prdata_ff <= {24'h00_0000, ctrl_ff};
            shift_compare_halfword_pkg::instr_off: prdata_ff <= instr_ff;
            shift_compare_halfword_pkg::status_off: prdata_ff <= {16'h0000, break_cnt_ff, 3'b000, done_ff,
                                                                  exc_ff, busy};
            shift_compare_halfword_pkg::gpr_sel_off: prdata_ff <= {27'h000_0000, gpr_sel_ff};
            shift_compare_halfword_pkg::gpr_data_off: prdata_ff <= (gpr_sel_ff == 5'h00) ? 32'h0000_0000 :
                                                                   general_register_file[gpr_sel_ff];
            default: prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

endmodule

// [design/shift_compare_halfword_pkg.sv]
// types and constants of the execution unit
// assumes apb access and a translating memory outside
package shift_compare_halfword_pkg;

   // -------------------------------------------------------------------
   // register map (byte addresses)
   // -------------------------------------------------------------------
   localparam logic [11:0] ctrl_off = 12'h000;
   localparam logic [11:0] instr_off = 12'h004;
   localparam logic [11:0] status_off = 12'h008;
   localparam logic [11:0] gpr_sel_off = 12'h00c;
   localparam logic [11:0] gpr_data_off = 12'h010;

   // ctrl fields
   localparam int ctrl_release_lsb = 0;
   localparam int ctrl_eva_bit = 4;
   localparam int ctrl_big_endian_bit = 5;
   localparam int ctrl_swapped_endian_bit = 6;
   localparam int ctrl_superscalar_bit = 7;
   localparam logic [7:0] ctrl_reset = 8'h02;
   localparam logic [3:0] min_release = 4'h2;

   // status fields
   localparam int status_busy_bit = 0;
   localparam int status_exc_lsb = 1;
   localparam int status_done_bit = 4;
   localparam int status_break_lsb = 8;

   // instruction word fields
   localparam int op_lsb = 28;
   localparam int reg_b_lsb = 21;
   localparam int reg_a_lsb = 16;
   localparam int dest_lsb = 11;
   localparam int user_off_msb = 8;

   // -------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      seh_op = 4'h0,
      store_halfword_op = 4'h1,
      store_halfword_user_space_op = 4'h2,
      shift_left_immediate_op = 4'h3,
      shift_left_variable_op = 4'h4,
      set_if_less_signed_op = 4'h5,
      set_if_less_signed_imm_op = 4'h6,
      set_if_less_unsigned_imm_op = 4'h7,
      set_if_less_unsigned_op = 4'h8
   } op_e;

   typedef enum logic [2:0] {
      exc_none = 3'h0,
      exc_reserved_instr = 3'h1,
      exc_address_error = 3'h2,
      exc_tlb_refill = 3'h3,
      exc_tlb_invalid = 3'h4,
      exc_tlb_modified = 3'h5,
      exc_watch = 3'h6
   } exc_e;

   typedef enum logic [1:0] {
      kernel_only_seg_mode = 2'h0,
      unmapped_user_seg_mode = 2'h1,
      mapped_shared_seg_mode = 2'h2,
      mapped_user_seg_mode = 2'h3
   } seg_mode_e;

   typedef struct packed {
      logic valid;
      logic [31:0] vaddr;
      logic user_map;
   } xlate_req_s;

   typedef struct packed {
      logic valid;
      logic [31:0] paddr;
      seg_mode_e seg_mode;
      exc_e exc;
   } xlate_rsp_s;

   typedef struct packed {
      logic valid;
      logic [31:0] paddr;
      logic [31:0] vaddr;
      logic [1:0] lane;
      logic [31:0] data;
   } mem_req_s;

endpackage

// [tb/xlate_mem_model.sv]
// translator and memory model facing the execution unit
// assumes one clock; delay, fault and segment mode come from the bench
`timescale 1ns/100ps
module xlate_mem_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire shift_compare_halfword_pkg::xlate_req_s xlate_req,
   output shift_compare_halfword_pkg::xlate_rsp_s xlate_rsp,
   input wire shift_compare_halfword_pkg::mem_req_s mem_req,
   output logic mem_ready,
   input wire logic [1:0] dly,
   input wire logic [2:0] exc_sel,
   input wire logic [1:0] seg_sel,
   output shift_compare_halfword_pkg::mem_req_s last_wr,
   output logic [7:0] n_wr
);
   // -------------------------------------------------------------------
   // answers
   // -------------------------------------------------------------------
   logic [1:0] cnt_ff;
   logic xans;
   logic mans;
   assign xans = xlate_req.valid && !xlate_rsp.valid && cnt_ff == dly;
   assign mans = mem_req.valid && !mem_ready && cnt_ff == dly;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 2'h0;
         xlate_rsp <= '0;
         mem_ready <= 1'b0;
         last_wr <= '0;
         n_wr <= 8'h00;
      end else begin
         cnt_ff <= (xans || mans || xlate_rsp.valid || mem_ready) ? 2'h0 : cnt_ff + 2'h1;
         xlate_rsp.valid <= xans;
         // distinct maps expose a wrong mapping
         xlate_rsp.paddr <= xans ? xlate_req.vaddr ^ (xlate_req.user_map ? 32'h2000_0000 : 32'h1000_0000)
            : ~xlate_rsp.paddr;
         xlate_rsp.seg_mode <= shift_compare_halfword_pkg::seg_mode_e'(seg_sel);
         xlate_rsp.exc <= shift_compare_halfword_pkg::exc_e'(exc_sel);
         mem_ready <= mans;
         if (mem_req.valid && mem_ready) begin
            last_wr <= mem_req;
            n_wr <= n_wr + 8'h01;
         end
      end
   end
endmodule

// [tb/shift_compare_halfword_sva.sv]
// checker on the execution unit's ports
// assumes binding to the top module
`timescale 1ns/100ps
module shift_compare_halfword_sva (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire shift_compare_halfword_pkg::xlate_req_s xlate_req,
   input wire shift_compare_halfword_pkg::xlate_rsp_s xlate_rsp,
   input wire shift_compare_halfword_pkg::mem_req_s mem_req,
   input wire logic mem_ready,
   input wire logic issue_break
);
   // -------------------------------------------------------------------
   // properties
   // -------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic xtake;
   assign xtake = xlate_req.valid && xlate_rsp.valid;
   apb_ready_a: assert property (pready) else $error("pready low");
   unmapped_err_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr) else $error("no slverr");
   mem_hold_a: assert property (mem_req.valid && !mem_ready |=> mem_req.valid && $stable(mem_req))
      else $error("store request moved");
   mem_drop_a: assert property (mem_req.valid && mem_ready |=> !mem_req.valid) else $error("store repeated");
   xreq_hold_a: assert property (xlate_req.valid && !xlate_rsp.valid |=>
      xlate_req.valid && $stable(xlate_req.vaddr)) else $error("xlate request moved");
   odd_block_a: assert property ((xlate_req.valid |-> !xlate_req.vaddr[0])
      and (mem_req.valid |-> !mem_req.vaddr[0])) else $error("odd address went out");
   lane_data_a: assert property (mem_req.valid |-> !mem_req.lane[0] &&
      (!mem_req.lane[1] || mem_req.data[15:0] == 16'h0000)) else $error("lane data wrong");
   exc_nowr_a: assert property (xtake && xlate_rsp.exc inside {[3'h3:3'h6]} |=> !mem_req.valid [*2])
      else $error("store after fault");
   take_wr_a: assert property (xtake && xlate_rsp.exc == 3'h0 &&
      (!xlate_req.user_map || xlate_rsp.seg_mode != 2'h0) |=> mem_req.valid &&
      mem_req.vaddr == $past(xlate_req.vaddr) && mem_req.paddr[31:2] == $past(xlate_rsp.paddr[31:2]))
      else $error("store address wrong");
   brk_pulse_a: assert property (issue_break |=> !issue_break) else $error("break not a pulse");
endmodule
bind shift_compare_halfword_exec shift_compare_halfword_sva chk (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .xlate_req(xlate_req),
   .xlate_rsp(xlate_rsp), .mem_req(mem_req), .mem_ready(mem_ready), .issue_break(issue_break));

// [tb/tb.sv]
// self-checking bench for the execution unit
// assumes package and model compiled first
`timescale 1ns/100ps
module tb;
   // -------------------------------------------------------------------
   // bench
   // -------------------------------------------------------------------
   logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q, st, a, b, r, ea;
   logic pready, pslverr, issue_break, mem_ready, e;
   logic [15:0] im;
   logic [3:0] op;
   logic [4:0] rd;
   logic [2:0] xe, exc_sel = 3'h0;
   logic [1:0] dly = 2'h0, seg_sel = 2'h0, ln;
   logic [7:0] n_wr, n0, c1;
   logic [3:0] ops [7] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
   shift_compare_halfword_pkg::xlate_req_s xlate_req;
   shift_compare_halfword_pkg::xlate_rsp_s xlate_rsp;
   shift_compare_halfword_pkg::mem_req_s mem_req, last_wr;
   int failures = 0, n_checks = 0, nb = 0;
   integer seed = 32'hd0a4ad80;
   shift_compare_halfword_exec dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .xlate_req(xlate_req), .xlate_rsp(xlate_rsp), .mem_req(mem_req), .mem_ready(mem_ready),
      .issue_break(issue_break));
   xlate_mem_model far (.sys_clk(sys_clk), .rst_n(rst_n), .xlate_req(xlate_req), .xlate_rsp(xlate_rsp),
      .mem_req(mem_req), .mem_ready(mem_ready), .dly(dly), .exc_sel(exc_sel), .seg_sel(seg_sel),
      .last_wr(last_wr), .n_wr(n_wr));
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task fail_out;
      failures++;
      give_verdict;
   endtask
   always @(posedge sys_clk) if (issue_break === 1'b1) nb++;
   task chk(input logic [95:0] g, x);
      n_checks++;
      if (g !== x) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int i;
      psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= d; penable <= 1'b0;
      @(posedge sys_clk);
      penable <= 1'b1;
      i = 0;
      do begin @(posedge sys_clk); i++; end while (pready !== 1'b1 && i < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge sys_clk);
      if (i >= 20) fail_out;
   endtask
   task setr(input logic [4:0] n, input logic [31:0] v);
      apb(1'b1, shift_compare_halfword_pkg::gpr_sel_off, {27'h0, n});
      apb(1'b1, shift_compare_halfword_pkg::gpr_data_off, v);
   endtask
   task getr(input logic [4:0] n);
      apb(1'b1, shift_compare_halfword_pkg::gpr_sel_off, {27'h0, n});
      apb(1'b0, shift_compare_halfword_pkg::gpr_data_off, 32'h0000_0000);
   endtask
   task automatic run(input logic [31:0] ins);
      int i;
      apb(1'b1, shift_compare_halfword_pkg::instr_off, ins);
      i = 0;
      do begin apb(1'b0, shift_compare_halfword_pkg::status_off, 32'h0000_0000); i++; end
         while (q[4] !== 1'b1 && i < 40);
      st = q;
      apb(1'b1, shift_compare_halfword_pkg::status_off, 32'h0000_0010);
      if (i >= 40) fail_out;
   endtask
   task ctl(input logic [31:0] v);
      apb(1'b1, shift_compare_halfword_pkg::ctrl_off, v);
   endtask
   function automatic logic [31:0] alu(input logic [3:0] o, input logic [31:0] x, y, input logic [15:0] m);
      logic [31:0] s;
      s = {{16{m[15]}}, m};
      case (o)
         4'h0: return {{16{x[15]}}, x[15:0]};
         4'h3: return x << m[15:11];
         4'h4: return y << x[4:0];
         4'h5: return {31'h0, $signed(x) < $signed(y)};
         4'h6: return {31'h0, $signed(x) < $signed(s)};
         4'h7: return {31'h0, x < s};
         default: return {31'h0, x < y};
      endcase
   endfunction
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (100000) @(posedge sys_clk);
      fail_out;
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      apb(1'b0, shift_compare_halfword_pkg::ctrl_off, 32'h0000_0000);
      chk({e, q}, {1'b0, 32'h0000_0002});
      apb(1'b0, 12'h020, 32'h0000_0000);
      chk({e, q}, {1'b1, 32'h0000_0000});
      $display("test registers done");
      for (int k = 0; k < 70; k++) begin
         op = ops[k % 7];
         a = $random(seed);
         b = $random(seed);
         r = $random(seed);
         im = r[15:0];
         if (k < 14) begin
            a = k < 7 ? 32'h8000_0000 : 32'h0000_801f;
            im = k < 7 ? 16'h8000 : 16'h7fff;
         end
         rd = (op inside {4'h0, 4'h3, 4'h6, 4'h7}) ? 5'd2 : im[15:11];
         setr(5'd1, a);
         setr(5'd2, b);
         run({op, 2'b00, 5'd2, 5'd1, im});
         getr(rd);
         chk(q, rd == 5'd0 ? 32'h0000_0000 : alu(op, a, b, im));
         chk(st[3:1], 3'h0);
      end
      $display("test alu done");
      ctl(32'h0000_0001);
      setr(5'd2, 32'h1234_5678);
      run({4'h0, 2'b00, 5'd2, 5'd1, 16'h0000});
      chk(st[3:1], 3'h1);
      getr(5'd2);
      chk(q, 32'h1234_5678);
      ctl(32'h0000_0002);
      n0 = n_wr;
      run({4'h2, 2'b00, 5'd2, 5'd1, 16'h0000});
      chk({st[3:1], n_wr}, {3'h1, n0});
      ctl(32'h0000_0082);
      run({4'h3, 12'h000, 16'h0800});
      c1 = st[15:8];
      run({4'h3, 28'h000_0000});
      chk(st[15:8], c1);
      run({4'h3, 12'h000, 16'h0800});
      chk(st[15:8], c1 + 8'h01);
      chk(nb, 2);
      setr(5'd0, 32'hffff_ffff);
      getr(5'd0);
      chk(q, 32'h0000_0000);
      $display("test idioms done");
      for (int k = 0; k < 32; k++) begin
         op = k[0] ? 4'h2 : 4'h1;
         a = $random(seed);
         b = $random(seed);
         im = a[31:16];
         r = $random(seed);
         exc_sel <= r[4] ? 3'h0 : {1'b0, r[3:2]} + 3'h3;
         seg_sel <= r[6:5];
         dly <= r[8:7];
         ctl({24'h0, 1'b0, r[1], r[0], 1'b1, 4'h2});
         setr(5'd1, a);
         setr(5'd2, b);
         ea = a + (op == 4'h1 ? {{16{im[15]}}, im} : {{23{im[8]}}, im[8:0]});
         xe = ea[0] ? 3'h2 : !r[4] ? {1'b0, r[3:2]} + 3'h3 : (op == 4'h2 && r[6:5] == 2'h0) ? 3'h2 : 3'h0;
         ln = ea[1:0] ^ {r[0], 1'b0};
         n0 = n_wr;
         run({op, 2'b00, 5'd2, 5'd1, im});
         chk(st[3:1], xe);
         chk(n_wr - n0, {7'h0, xe == 3'h0});
         if (xe == 3'h0)
            chk({last_wr.paddr, last_wr.lane, last_wr.data}, {ea ^ (op == 4'h2 ? 32'h2000_0000 : 32'h1000_0000)
               ^ {30'h0, r[1], 1'b0}, ln, b << {ln, 3'b000}});
      end
      $display("test stores done");
      give_verdict;
   end
endmodule
